//--- src/rspc_pkg.sv
// Package: register map, field positions, reset values and timing counts
package rspc_pkg;
    // Register byte addresses
    localparam logic [11:0] ANALOG_POWER_GATING_OFS = 12'h0f80;
    localparam logic [11:0] PORT_MODE_OFS           = 12'h0f84;
    localparam logic [11:0] RECOVERY_SRC_OFS        = 12'h0f88;
    localparam logic [11:0] RESET_STATUS_OFS        = 12'h0f8c;
    // Analog power gating field positions
    localparam int LOW_POWER_AMP_DISABLE_BIT = 7;
    localparam int BROWNOUT_DISABLE_BIT      = 4;
    localparam int TEMP_DISABLE_BIT          = 3;
    localparam int ADC_DISABLE_BIT           = 2;
    localparam int COMP_DISABLE_BIT          = 1;
    // Port mode field positions
    localparam int PD0_RESET_AF_BIT = 7;
    localparam int PORT_AF_LSB      = 0;
    localparam int PORT_OE_LSB      = 3;
    // Reset status field positions
    localparam int CAUSE_POR_BIT   = 7;
    localparam int CAUSE_BO_BIT    = 6;
    localparam int CAUSE_WDT_BIT   = 5;
    localparam int CAUSE_EXT_BIT   = 4;
    localparam int CAUSE_DBG_BIT   = 3;
    localparam int CAUSE_SMR_BIT   = 2;
    localparam int LIVE_LV_BIT     = 1;
    localparam int LIVE_STOP_BIT   = 0;
    // Reset values
    localparam logic [7:0] ANALOG_POWER_GATING_RST = 8'h0080;
    localparam logic [7:0] PORT_MODE_RST           = 8'h0080;
    localparam logic [7:0] RECOVERY_SRC_RST        = 8'h0000;
    localparam logic [7:0] RESET_STATUS_RST        = 8'h0080;
    // Timing: clock period and reset stretch times in ns
    localparam int CLK_PERIOD_NS  = 10;
    localparam int RESET_HOLD_NS  = 1000;
    localparam int XTAL_EXTRA_NS  = 5000;
    localparam int RESET_HOLD_CYC =
        (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int XTAL_EXTRA_CYC =
        (XTAL_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Sequencer states
    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_HOLD  = 3'b010,
        ST_COUNT = 3'b100
    } rspc_state_t;
endpackage

//--- src/rspc_sync_if.sv
// Interface: raw asynchronous inputs and their synchronised copies
interface rspc_sync_if #(parameter int W = 13);
    logic [W-1:0] raw;     // Straight from the pins
    logic [W-1:0] synced;  // After two flops
    modport sync_side (input raw, output synced);
    modport user_side (output raw, input synced);
endinterface

//--- src/rspc_sync.sv
// Two-flop synchroniser bank for asynchronous inputs
module rspc_sync #(
    parameter int W = 13
) (
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       arst_n_in,
    // Raw in, synced out
    rspc_sync_if.sync_side  sif
);
    // All state of the bank
    typedef struct packed {
        logic [W-1:0] stage1;  // Metastable catch, read by stage2 only
        logic [W-1:0] stage2;  // Safe copy
    } rspc_sync_regs_t;

    rspc_sync_regs_t r_reg;
    rspc_sync_regs_t r_next;

    ////////////////////////////////////////////////////////////////////
    // Next state: one shift per bit
    always_comb begin
        r_next = r_reg;
        for (int i = 0; i < W; i++) begin
            r_next.stage1[i] = sif.raw[i];
            r_next.stage2[i] = r_reg.stage1[i];
        end
    end

    // State register
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign sif.synced = r_reg.stage2;
endmodule

//--- src/rspc_top.sv
// Reset, stop mode recovery and analog power gating controller
// Notes on behaviour
// - Any reset: ports A-C inputs, no alternates
// - Power-up: port D bit zero is reset
// - Watchdog resets outside stop only when option selects reset
// - Reset pin acts only with alternate enabled
// - Debugger control bit 0 forces reset
// - Low supply gives brown-out reset
// - Stop: watchdog or enabled pin edge recovers
// - Recovery runs through the same sequencer
// - Eight-pin parts: low supply raises interrupt
// - Crystal option lengthens the reset
// - Power register reset only by power-on
// - Bit 7 disables amp, resets to one
// - Enabled amp stays powered in stop
// - Bit 3 zero enables temperature sensor
// - Bit 2 zero enables converter
// - Bit 1 zero enables comparator
module rspc_top #(
    parameter int          CNT_W     = 10,
    parameter int          HOLD_CYC  = rspc_pkg::RESET_HOLD_CYC,
    parameter int          XTAL_CYC  = rspc_pkg::XTAL_EXTRA_CYC,
    parameter bit          EIGHT_PIN = 1'b1,
    parameter int          GPIO_W    = 8
) (
    // Clock and power-on reset
    input  wire logic              clock_in,
    input  wire logic              arst_n_in,
    // Register port
    input  wire logic [11:0]       addr_in,
    input  wire logic [7:0]        wdata_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    output logic      [7:0]        rdata_out,
    // Asynchronous sources
    input  wire logic              supply_brownout_in,
    input  wire logic              low_voltage_in,
    input  wire logic              watchdog_timeout_in,
    input  wire logic              reset_pin_n_in,
    input  wire logic [7:0]        debug_controller_control_in,
    input  wire logic [GPIO_W-1:0] gpio_in,
    // Nonvolatile options and core status
    input  wire logic              watchdog_reset_select_option_in,
    input  wire logic              brownout_option_en_in,
    input  wire logic              xtal_option_en_in,
    input  wire logic              stop_mode_in,
    // Reset and recovery outputs
    output logic                   sys_reset_n_out,
    output logic                   smr_active_out,
    output logic                   watchdog_irq_out,
    output logic                   low_voltage_irq_out,
    // Pin defaults
    output logic [2:0]             port_af_en_out,
    output logic [2:0]             port_out_en_out,
    output logic                   port_d_bit_zero_reset_af_out,
    // Analog power enables
    output logic                   amp_power_on_out,
    output logic                   brownout_det_en_out,
    output logic                   temp_sensor_en_out,
    output logic                   adc_en_out,
    output logic                   comp_en_out
);
    localparam int SYNC_W = 5 + GPIO_W;  // Synchronised bit count

    // All state of the controller
    typedef struct packed {
        rspc_pkg::rspc_state_t state;  // Sequencer
        logic [CNT_W-1:0]  cnt;        // Stretch counter
        logic [7:0]        analog;     // Analog power gating
        logic [7:0]        port_mode;  // Pin mode control
        logic [GPIO_W-1:0] smr_en;     // Recovery pin enables
        logic [7:0]        status;     // Latched reset cause
        logic              wdt_prev;   // Watchdog edge memory
        logic [GPIO_W-1:0] gpio_prev;  // Pin edge memory
        logic [7:0]        rdata;      // Read data
        logic              wdt_irq;    // Watchdog interrupt pulse
        logic              lv_irq;     // Low voltage request
    } rspc_regs_t;

    rspc_regs_t r_reg;
    rspc_regs_t r_next;

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers
    rspc_sync_if #(.W(SYNC_W)) sif ();

    assign sif.raw = {gpio_in, low_voltage_in,
                      debug_controller_control_in[0], ~reset_pin_n_in,
                      watchdog_timeout_in, supply_brownout_in};

    rspc_sync #(.W(SYNC_W)) u_sync (
        .clock_in  (clock_in),
        .arst_n_in (arst_n_in),
        .sif       (sif)
    );

    // Synchronised views
    logic              bo_s;        // Supply below safe level
    logic              wdt_s;       // Watchdog time-out level
    logic              ext_s;       // Reset pin asserted
    logic              dbg_s;       // Debugger reset bit
    logic              lv_s;        // Supply below user level
    logic [GPIO_W-1:0] gpio_s;      // Port pins

    assign bo_s   = sif.synced[0];
    assign wdt_s  = sif.synced[1];
    assign ext_s  = sif.synced[2];
    assign dbg_s  = sif.synced[3];
    assign lv_s   = sif.synced[4];
    assign gpio_s = sif.synced[SYNC_W-1:5];

    ////////////////////////////////////////////////////////////////////
    // Source qualification
    logic             bo_det_en;   // Detector armed
    logic             bo_hold;     // Brown-out request
    logic             ext_hold;    // Pin request
    logic             any_hold;    // Level sources
    logic             wdt_edge;    // New time-out
    logic             wdt_reset;   // Time-out chosen as reset
    logic             smr_start;   // Stop recovery event
    logic [CNT_W-1:0] target;      // Stretch length

    // Detector needs both register and option enable
    assign bo_det_en = !r_reg.analog[rspc_pkg::BROWNOUT_DISABLE_BIT]
                       && brownout_option_en_in;
    assign bo_hold   = bo_det_en && bo_s;
    // Pin counts only with its reset alternate enabled
    assign ext_hold  = ext_s &&
        r_reg.port_mode[rspc_pkg::PD0_RESET_AF_BIT];
    assign any_hold  = bo_hold || ext_hold || dbg_s;
    assign wdt_edge  = wdt_s && !r_reg.wdt_prev;
    assign wdt_reset = wdt_edge && !stop_mode_in &&
                       watchdog_reset_select_option_in;
    // Stop recovery: watchdog or an enabled pin transition
    assign smr_start = stop_mode_in && (wdt_edge ||
        |((gpio_s ^ r_reg.gpio_prev) & r_reg.smr_en));
    // Crystal option adds start-up time
    assign target = xtal_option_en_in
        ? CNT_W'(HOLD_CYC + XTAL_CYC - 1)
        : CNT_W'(HOLD_CYC - 1);

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        r_next           = r_reg;
        r_next.wdt_prev  = wdt_s;
        r_next.gpio_prev = gpio_s;
        r_next.rdata     = 8'h0000;
        // Interrupt response when reset not selected
        r_next.wdt_irq   = wdt_edge && !stop_mode_in &&
                           !watchdog_reset_select_option_in;
        r_next.lv_irq    = EIGHT_PIN && lv_s;

        // Register writes
        if (wr_in) begin
            unique case (addr_in)
                rspc_pkg::ANALOG_POWER_GATING_OFS: begin
                    // Reserved bits kept as written
                    r_next.analog = wdata_in;
                end
                rspc_pkg::PORT_MODE_OFS: begin
                    r_next.port_mode = wdata_in;
                end
                rspc_pkg::RECOVERY_SRC_OFS: begin
                    r_next.smr_en = wdata_in[GPIO_W-1:0];
                end
                default: begin
                    // Status and unmapped: ignored
                end
            endcase
        end

        // Register reads, data next cycle
        if (rd_in) begin
            unique case (addr_in)
                rspc_pkg::ANALOG_POWER_GATING_OFS: begin
                    r_next.rdata = r_reg.analog;
                end
                rspc_pkg::PORT_MODE_OFS: begin
                    r_next.rdata = r_reg.port_mode;
                end
                rspc_pkg::RECOVERY_SRC_OFS: begin
                    r_next.rdata = 8'(r_reg.smr_en);
                end
                rspc_pkg::RESET_STATUS_OFS: begin
                    r_next.rdata = r_reg.status;
                    r_next.rdata[rspc_pkg::LIVE_LV_BIT]   = lv_s;
                    r_next.rdata[rspc_pkg::LIVE_STOP_BIT] = stop_mode_in;
                end
                default: begin
                    // Unmapped reads as zero
                end
            endcase
        end

        // Reset sequencer
        unique case (r_reg.state)
            rspc_pkg::ST_RUN: begin
                if (any_hold) begin
                    // Level sources hold reset while present
                    r_next.state  = rspc_pkg::ST_HOLD;
                    r_next.status = 8'h0000;
                    r_next.status[rspc_pkg::CAUSE_BO_BIT]  = bo_hold;
                    r_next.status[rspc_pkg::CAUSE_EXT_BIT] = ext_hold;
                    r_next.status[rspc_pkg::CAUSE_DBG_BIT] = dbg_s;
                end else if (wdt_reset || smr_start) begin
                    // Pulse sources go straight to stretch
                    r_next.state  = rspc_pkg::ST_COUNT;
                    r_next.cnt    = '0;
                    r_next.status = 8'h0000;
                    r_next.status[rspc_pkg::CAUSE_WDT_BIT] = wdt_edge;
                    r_next.status[rspc_pkg::CAUSE_SMR_BIT] = smr_start;
                end
            end
            rspc_pkg::ST_HOLD: begin
                // Wait for every level source to drop
                if (!any_hold) begin
                    r_next.state = rspc_pkg::ST_COUNT;
                    r_next.cnt   = '0;
                end
            end
            rspc_pkg::ST_COUNT: begin
                if (any_hold) begin
                    // Source came back: restart
                    r_next.state = rspc_pkg::ST_HOLD;
                end else if (r_reg.cnt >= target) begin
                    r_next.state = rspc_pkg::ST_RUN;
                end else begin
                    r_next.cnt = r_reg.cnt + CNT_W'(1);
                end
            end
        endcase

        // Any reset: ports A-C inputs, alternates off; port D bit zero reset alternate kept
        if (r_next.state != rspc_pkg::ST_RUN) begin
            r_next.port_mode[rspc_pkg::PORT_OE_LSB +: 3] = 3'h0;
            r_next.port_mode[rspc_pkg::PORT_AF_LSB +: 3] = 3'h0;
            if (!r_next.status[rspc_pkg::CAUSE_SMR_BIT]) begin
                r_next.smr_en = '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register; power-on is the only analog reset
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            r_reg.state     <= rspc_pkg::ST_COUNT;
            r_reg.cnt       <= '0;
            r_reg.analog    <= rspc_pkg::ANALOG_POWER_GATING_RST;
            r_reg.port_mode <= rspc_pkg::PORT_MODE_RST;
            r_reg.smr_en    <= '0;
            r_reg.status    <= rspc_pkg::RESET_STATUS_RST;
            r_reg.wdt_prev  <= 1'b0;
            r_reg.gpio_prev <= '0;
            r_reg.rdata     <= 8'h0000;
            r_reg.wdt_irq   <= 1'b0;
            r_reg.lv_irq    <= 1'b0;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign rdata_out           = r_reg.rdata;
    assign sys_reset_n_out     = (r_reg.state == rspc_pkg::ST_RUN);
    assign smr_active_out      = !sys_reset_n_out &&
                                 r_reg.status[rspc_pkg::CAUSE_SMR_BIT];
    assign watchdog_irq_out    = r_reg.wdt_irq;
    assign low_voltage_irq_out = r_reg.lv_irq;
    assign port_af_en_out      = r_reg.port_mode[rspc_pkg::PORT_AF_LSB +: 3];
    assign port_out_en_out     = r_reg.port_mode[rspc_pkg::PORT_OE_LSB +: 3];
    assign port_d_bit_zero_reset_af_out =
        r_reg.port_mode[rspc_pkg::PD0_RESET_AF_BIT];
    // Amp not gated by stop mode
    assign amp_power_on_out =
        !r_reg.analog[rspc_pkg::LOW_POWER_AMP_DISABLE_BIT];
    assign brownout_det_en_out = bo_det_en;
    assign temp_sensor_en_out  =
        !r_reg.analog[rspc_pkg::TEMP_DISABLE_BIT];
    assign adc_en_out  = !r_reg.analog[rspc_pkg::ADC_DISABLE_BIT];
    assign comp_en_out = !r_reg.analog[rspc_pkg::COMP_DISABLE_BIT];

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);

    // Recovery entry: stop event then sequencer in reset
    sequence s_smr_event;
        sys_reset_n_out && !any_hold && smr_start;
    endsequence
    sequence s_smr_reset;
        !sys_reset_n_out && smr_active_out;
    endsequence

    AST_PORTS_RESET: assert property (
        !sys_reset_n_out |-> port_af_en_out == 3'h0 &&
                             port_out_en_out == 3'h0)
        else $error("Port alternates active during reset");
    AST_PD0_POR: assert property (
        r_reg.status[rspc_pkg::CAUSE_POR_BIT] && !sys_reset_n_out
        |-> port_d_bit_zero_reset_af_out)
        else $error("Port D bit zero not reset after power-up");
    AST_WDT_RESET: assert property (
        sys_reset_n_out && wdt_edge && !stop_mode_in &&
        watchdog_reset_select_option_in |=> !sys_reset_n_out)
        else $error("Watchdog time-out did not reset");
    AST_EXT_PIN: assert property (
        ext_s && port_d_bit_zero_reset_af_out
        |=> !sys_reset_n_out [*2])
        else $error("Reset pin ignored");
    AST_DEBUG: assert property (
        dbg_s |=> !sys_reset_n_out)
        else $error("Debugger reset ignored");
    AST_BROWNOUT: assert property (
        bo_s && brownout_det_en_out |=> !sys_reset_n_out)
        else $error("Brown-out did not reset");
    AST_SMR: assert property (
        s_smr_event |=> s_smr_reset)
        else $error("Stop recovery not started");
    AST_SMR_SEQ: assert property (
        s_smr_event |=> s_smr_reset ##1 !sys_reset_n_out)
        else $error("Recovery skipped the sequencer");
    AST_LV_IRQ: assert property (
        lv_s |=> low_voltage_irq_out == EIGHT_PIN)
        else $error("Low voltage request wrong");
    AST_XTAL_LEN: assert property (
        $rose(sys_reset_n_out) && $past(xtal_option_en_in)
        |-> $past(r_reg.cnt) == CNT_W'(HOLD_CYC + XTAL_CYC - 1))
        else $error("Reset stretch length wrong");
    AST_ANALOG_KEEP: assert property (
        !sys_reset_n_out && !wr_in |=> $stable(r_reg.analog))
        else $error("Power register changed by reset");
    AST_AMP_STOP: assert property (
        wr_in && addr_in == rspc_pkg::ANALOG_POWER_GATING_OFS &&
        !wdata_in[7] ##1 stop_mode_in [*2] |-> amp_power_on_out)
        else $error("Amp dropped in stop");
    AST_ADC_WR: assert property (
        wr_in && addr_in == rspc_pkg::ANALOG_POWER_GATING_OFS
        |=> adc_en_out == !$past(wdata_in[2]) &&
            comp_en_out == !$past(wdata_in[1]))
        else $error("Converter enables do not follow write");
    AST_BO_GATE: assert property (
        wr_in && addr_in == rspc_pkg::ANALOG_POWER_GATING_OFS &&
        wdata_in[4] |=> !brownout_det_en_out)
        else $error("Brown-out detector not gated");
endmodule

//--- test/rspc_far_model.sv
// Far side model: supply monitors, reset pin, debugger and port pins
module rspc_far_model (
    // Clock
    input  wire logic clock_in,
    // Source levels seen by the block
    output logic       brownout_out,
    output logic       low_voltage_out,
    output logic       wdt_out,
    output logic       pin_n_out,
    output logic [7:0] dbg_out,
    output logic [7:0] gpio_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle levels: supply good, pin pulled high
    initial begin
        brownout_out    = 1'b0;
        low_voltage_out = 1'b0;
        wdt_out         = 1'b0;
        pin_n_out       = 1'b1;
        dbg_out         = 8'h00;
        gpio_out        = 8'h00;
    end
    // Change one source just after a rising edge
    task automatic drive(input int src, input logic [7:0] v);
        @(posedge clock_in);
        case (src)
            0: brownout_out <= v[0];
            1: low_voltage_out <= v[0];
            2: wdt_out <= v[0];
            3: pin_n_out <= ~v[0];
            4: dbg_out <= {7'($urandom), v[0]};  // Upper bits are noise
            default: gpio_out <= v;
        endcase
    endtask
endmodule

//--- test/tb.sv
// Testbench: reset sources, recovery and power gating register
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int XTAL = 8;  // Small crystal stretch for short runs
    // Clock, reset and register port
    logic clock_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [11:0] addr_in = 12'h000;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] rdata_out;
    // Far side levels and options
    logic bo, lv, wdt, pin_n;
    logic [7:0] dbg, gpio;
    logic wsel = 1'b0, bo_opt = 1'b0, xtal = 1'b0, stop = 1'b0;
    // Design outputs
    logic sys_n, smr, wirq, lvirq, pd0, amp, bod, temp, adc, comp;
    logic [2:0] af, oe;
    int err_count = 0;
    int cmp_count = 0;
    always #5 clock_in = ~clock_in;
    rspc_far_model rspc_far_model_i (.clock_in(clock_in), .brownout_out(bo),
        .low_voltage_out(lv), .wdt_out(wdt), .pin_n_out(pin_n),
        .dbg_out(dbg), .gpio_out(gpio));
    rspc_top #(.HOLD_CYC(4), .XTAL_CYC(XTAL)) rspc_top_i (
        .clock_in(clock_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .supply_brownout_in(bo),
        .low_voltage_in(lv), .watchdog_timeout_in(wdt),
        .reset_pin_n_in(pin_n), .debug_controller_control_in(dbg),
        .gpio_in(gpio), .watchdog_reset_select_option_in(wsel),
        .brownout_option_en_in(bo_opt), .xtal_option_en_in(xtal),
        .stop_mode_in(stop), .sys_reset_n_out(sys_n),
        .smr_active_out(smr), .watchdog_irq_out(wirq),
        .low_voltage_irq_out(lvirq), .port_af_en_out(af),
        .port_out_en_out(oe), .port_d_bit_zero_reset_af_out(pd0),
        .amp_power_on_out(amp), .brownout_det_en_out(bod),
        .temp_sensor_en_out(temp), .adc_en_out(adc), .comp_en_out(comp));
    ////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input string n, input logic [7:0] e, g);
        cmp_count++;
        if (g !== e) begin
            $display("[ERR] %s exp %h got %h", n, e, g);
            err_count++;
        end
    endtask
    // Expected enables {amp, bod, temp, adc, comp} for a written value
    function automatic logic [4:0] exp_en(logic [7:0] v, logic o);
        return {~v[7], ~v[4] & o, ~v[3:1]};
    endfunction
    // One-cycle register write
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask
    // One-cycle read, data taken in the following cycle
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    // Raise a source, release it, measure the reset length (-1 if none)
    task automatic trig(input int src, input logic [7:0] v, rel,
                        output int len, output logic s, w);
        int i;
        len = -1;
        s = 1'b0;
        w = 1'b0;
        rspc_far_model_i.drive(src, v);
        for (i = 0; i < 12 && sys_n === 1'b1; i++) begin
            @(posedge clock_in);
            #1 w = w | (wirq === 1'b1);
        end
        s = (smr === 1'b1);
        rspc_far_model_i.drive(src, rel);
        if (sys_n === 1'b0) begin
            len = 0;
            while (sys_n !== 1'b1 && len < 900) begin
                @(posedge clock_in);
                #1 len++;
            end
        end
        repeat (4) @(posedge clock_in);
    endtask
    // Verdict and end of run
    task automatic end_of_test();
        $display("Checks %0d, errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clock_in);
        err_count++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int s, i, la, lb;
        logic [7:0] d, v;
        logic [4:0] e;
        logic sm, wi;
        s = $urandom(65611);
        repeat (20) @(posedge clock_in);
        arst_n_in <= 1'b1;
        for (i = 0; i < 200 && sys_n !== 1'b1; i++) @(posedge clock_in);
        rd(rspc_pkg::ANALOG_POWER_GATING_OFS, d);
        chk("analog_rst", 8'h80, d);
        chk("amp_on", 8'h00, 8'(amp));
        chk("en_rst", 8'h07, 8'({temp, adc, comp}));
        chk("port_af", 8'h00, 8'({af, oe}));
        chk("pd0_af", 8'h01, 8'(pd0));
        rd(12'hf90, d);
        chk("unmapped", 8'h00, d);
        // Power gating fields, corners then random, reserved bits zero
        for (i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'h9e : 8'($urandom) & 8'h9e;
            bo_opt <= 1'($urandom);
            wr(rspc_pkg::ANALOG_POWER_GATING_OFS, v);
            rd(rspc_pkg::ANALOG_POWER_GATING_OFS, d);
            e = exp_en(v, bo_opt);
            chk("analog_rb", v, d);
            chk("amp", {7'h00, e[4]}, 8'(amp));
            chk("bod", {7'h00, e[3]}, 8'(bod));
            chk("ts_adc_cmp", {5'h00, e[2:0]}, 8'({temp, adc, comp}));
        end
        wr(rspc_pkg::ANALOG_POWER_GATING_OFS, 8'h0a);
        wr(rspc_pkg::PORT_MODE_OFS, 8'hbf);
        // Debugger reset keeps power register, clears port functions
        trig(4, 8'h01, 8'h00, la, sm, wi);
        chk("dbg_rst", 8'h01, 8'(la >= 0));
        rd(rspc_pkg::ANALOG_POWER_GATING_OFS, d);
        chk("analog_kept", 8'h0a, d);
        rd(rspc_pkg::PORT_MODE_OFS, d);
        chk("port_mode", 8'h80, d);
        chk("port_af2", 8'h00, 8'({af, oe}));
        xtal <= 1'b1;
        trig(4, 8'h01, 8'h00, lb, sm, wi);
        xtal <= 1'b0;
        chk("xtal_extra", 8'(XTAL), 8'(lb - la));
        // Reset pin with and without its function
        trig(3, 8'h01, 8'h00, la, sm, wi);
        chk("pin_rst", 8'h01, 8'(la >= 0));
        wr(rspc_pkg::PORT_MODE_OFS, 8'h00);
        trig(3, 8'h01, 8'h00, la, sm, wi);
        chk("pin_off", 8'h00, 8'(la >= 0));
        wr(rspc_pkg::PORT_MODE_OFS, 8'h80);
        // Watchdog: interrupt with option clear, reset with it set
        trig(2, 8'h01, 8'h00, la, sm, wi);
        chk("wdt_irq", 8'h01, 8'({la >= 0, wi}));
        wsel <= 1'b1;
        trig(2, 8'h01, 8'h00, la, sm, wi);
        chk("wdt_rst", 8'h01, 8'(la >= 0));
        wsel <= 1'b0;
        // Brown-out with detector on, then option off
        bo_opt <= 1'b1;
        trig(0, 8'h01, 8'h00, la, sm, wi);
        chk("bo_rst", 8'h01, 8'(la >= 0));
        bo_opt <= 1'b0;
        trig(0, 8'h01, 8'h00, la, sm, wi);
        chk("bo_off", 8'h00, 8'(la >= 0));
        // Low supply interrupt follows the monitor
        rspc_far_model_i.drive(1, 8'h01);
        repeat (4) @(posedge clock_in);
        #1 chk("lv_irq", 8'h01, 8'(lvirq));
        rspc_far_model_i.drive(1, 8'h00);
        repeat (4) @(posedge clock_in);
        #1 chk("lv_irq_off", 8'h00, 8'(lvirq));
        // Stop recovery: disabled pin, enabled pin, watchdog
        wr(rspc_pkg::RECOVERY_SRC_OFS, 8'h01);
        wr(rspc_pkg::ANALOG_POWER_GATING_OFS, 8'h0a);
        stop <= 1'b1;
        trig(5, 8'h02, 8'h02, la, sm, wi);
        chk("smr_off", 8'h00, 8'(la >= 0));
        chk("amp_stop", 8'h01, 8'(amp));
        trig(5, 8'h03, 8'h03, la, sm, wi);
        chk("smr_pin", 8'h03, 8'({la >= 0, sm}));
        rd(rspc_pkg::RESET_STATUS_OFS, d);
        chk("smr_cause", 8'h04, d & 8'h04);
        trig(2, 8'h01, 8'h00, la, sm, wi);
        chk("smr_wdt", 8'h03, 8'({la >= 0, sm}));
        stop <= 1'b0;
        end_of_test();
    end
endmodule
